// ### design/ras_pkg.sv
// package: constants of the return address stack block
package ras_pkg;
  localparam int PC_W = 21;
  localparam int SP_W = 5;
  localparam logic [20:0] RESET_VECTOR = 21'h000000;
  localparam logic [20:0] HI_VECTOR = 21'h000008;
  localparam logic [20:0] LO_VECTOR = 21'h000018;
  localparam logic [20:0] MEM_32K_BYTES = 21'h008000;
  localparam logic [20:0] MEM_16K_BYTES = 21'h004000;
  localparam logic [15:0] NOP_WORD = 16'h0000;
  localparam logic [4:0] SP_EMPTY = 5'h00;
  localparam logic [4:0] SP_LIMIT = 5'h1F;
  localparam logic [4:0] SP_ONE = 5'h01;
  localparam logic [20:0] PC_STEP = 21'h000002;
  // register byte addresses on apb
  localparam logic [11:0] ADDR_POINTER = 12'h000;
  localparam logic [11:0] ADDR_TOP_LOW = 12'h004;
  localparam logic [11:0] ADDR_TOP_HIGH = 12'h008;
  localparam logic [11:0] ADDR_TOP_UPPER = 12'h00C;
  localparam logic [11:0] ADDR_CONFIG = 12'h010;
  localparam logic [11:0] ADDR_PC = 12'h014;
  // stack pointer register fields
  localparam int FULL_BIT = 7;
  localparam int UNF_BIT = 6;
  localparam logic [7:0] SPR_RESET = 8'h00;
  localparam logic CFG_OVF_RESET_DEFAULT = 1'b1;
  typedef enum logic [3:0] {
    RAS_OP_IDLE = 4'b0001,
    RAS_OP_PUSH = 4'b0010,
    RAS_OP_POP = 4'b0100,
    RAS_OP_IRQ = 4'b1000
  } ras_op_t;
endpackage

// ### design/ras_prog_mem.sv
// file: program memory with zero fill beyond the implemented size
`timescale 1ns/1ns
module ras_prog_mem #(
  parameter bit SIZE_32K = 1'b1
) (
  input wire logic clk_in,
  input wire logic [20:0] addr_in,
  input wire logic wr_in,
  input wire logic [15:0] wdata_in,
  output logic [15:0] rdata_out
);
  localparam logic [20:0] LIMIT = SIZE_32K ? ras_pkg::MEM_32K_BYTES : ras_pkg::MEM_16K_BYTES;
  // one 16-bit word per two bytes of implemented space
  localparam int WORDS = int'(LIMIT >> 1);
  logic [15:0] mem [WORDS];
  logic [15:0] rdata_d;
  logic [15:0] rdata_q;
  logic in_range;
  assign in_range = addr_in < LIMIT;
  // fetches past the implemented array read as all zeros (a nop)
  always_comb begin
    if (in_range) begin
      rdata_d = mem[addr_in[14:1] & 14'(WORDS - 1)];
    end else begin
      rdata_d = ras_pkg::NOP_WORD;
    end
  end
  always_ff @(posedge clk_in) begin
    if (wr_in && in_range) begin
      mem[addr_in[14:1] & 14'(WORDS - 1)] <= wdata_in;
    end
    rdata_q <= rdata_d;
  end
  assign rdata_out = rdata_q;
endmodule

// ### design/ras_top.sv
// file: return address stack, program counter and apb register slave
//
// Implementation choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
// Function
// - program counter is 21 bits wide
// - reset at zero, interrupts vector 08h/18h
// - fetch above implemented memory returns zero
// - memory size is a build parameter
// - push on push, call, relcall, interrupt
// - returns pop pc, latches untouched
// - 31 words of 21 bits, 5-bit pointer
// - every reset clears the pointer
// - pointer zero has no storage word
// - push increments pointer then writes
// - pop reads word then decrements pointer
// - stack lies outside program and data space
// - software reads and writes the pointer
// - three byte registers access top word
// - flags show pointer at or past limit
// - program and data memories on separate buses
// - interrupt wake pushes pc, loads vector
// - full after 31 pushes, software clears
// - overflow enable: reset, else hold at 31
// - empty pop gives zero, sets underflow
// - pointer register bit layout
module ras_top #(
  parameter bit SIZE_32K = 1'b1
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic por_in,
  input wire logic push_in,
  input wire logic pop_in,
  input wire logic irq_ack_in,
  input wire logic irq_high_in,
  input wire logic [20:0] branch_pc_in,
  input wire logic branch_in,
  input wire logic [20:0] data_addr_in,
  input wire logic data_rd_in,
  input wire logic [31:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [20:0] pc_out,
  output logic [15:0] instr_out,
  output logic [20:0] data_addr_out,
  output logic data_rd_out,
  output logic stack_reset_out
);
  // ==========================================================
  // storage and state
  logic [20:0] stack_q [1:31];
  logic [4:0] sp_q, sp_d;
  logic full_q, full_d;
  logic unf_q, unf_d;
  logic ovf_en_q, ovf_en_d;
  logic [20:0] pc_q, pc_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  logic stk_rst_q, stk_rst_d;
  logic [20:0] dad_q;
  logic drd_q;
  logic wr_en;
  logic [4:0] wr_idx;
  logic [20:0] wr_val;
  ras_pkg::ras_op_t op;
  logic acc, bus_wr;
  logic [11:0] a;
  logic [20:0] tos;
  logic [15:0] fetch_word;

  assign a = paddr[11:0];
  assign acc = psel && penable && !pready_q;
  assign bus_wr = acc && pwrite;
  assign tos = (sp_q == ras_pkg::SP_EMPTY) ? 21'h000000 : stack_q[sp_q];

  // ==========================================================
  // operation decode: interrupt first, then push, then pop
  always_comb begin
    if (irq_ack_in) begin
      op = ras_pkg::RAS_OP_IRQ;
    end else if (push_in) begin
      op = ras_pkg::RAS_OP_PUSH;
    end else if (pop_in) begin
      op = ras_pkg::RAS_OP_POP;
    end else begin
      op = ras_pkg::RAS_OP_IDLE;
    end
  end

  // ==========================================================
  // pointer, flags, pc and stack write port
  always_comb begin
    sp_d = sp_q;
    full_d = full_q;
    unf_d = unf_q;
    ovf_en_d = ovf_en_q;
    pc_d = pc_q + ras_pkg::PC_STEP;
    stk_rst_d = 1'b0;
    wr_en = 1'b0;
    wr_idx = sp_q;
    wr_val = pc_q;
    if (branch_in) begin
      pc_d = branch_pc_in; // latches not used for direct branches
    end
    // software writes come first so hardware events win over clears
    if (bus_wr) begin
      case (a)
        ras_pkg::ADDR_POINTER: begin
          sp_d = pwdata[4:0];
          if (!pwdata[ras_pkg::FULL_BIT]) full_d = 1'b0;
          if (!pwdata[ras_pkg::UNF_BIT]) unf_d = 1'b0;
        end
        ras_pkg::ADDR_TOP_LOW: begin
          wr_en = sp_q != ras_pkg::SP_EMPTY;
          wr_val = {tos[20:8], pwdata[7:0]};
        end
        ras_pkg::ADDR_TOP_HIGH: begin
          wr_en = sp_q != ras_pkg::SP_EMPTY;
          wr_val = {tos[20:16], pwdata[7:0], tos[7:0]};
        end
        ras_pkg::ADDR_TOP_UPPER: begin
          wr_en = sp_q != ras_pkg::SP_EMPTY;
          wr_val = {pwdata[4:0], tos[15:0]};
        end
        ras_pkg::ADDR_CONFIG: ovf_en_d = pwdata[0];
        default: ;
      endcase
    end
    case (op)
      ras_pkg::RAS_OP_PUSH, ras_pkg::RAS_OP_IRQ: begin
        wr_en = 1'b1;
        wr_val = pc_q;
        if (sp_q == ras_pkg::SP_LIMIT) begin
          wr_idx = ras_pkg::SP_LIMIT; // overwrite top
        end else begin
          sp_d = sp_q + ras_pkg::SP_ONE;
          wr_idx = sp_q + ras_pkg::SP_ONE;
        end
        if (sp_q >= ras_pkg::SP_LIMIT - ras_pkg::SP_ONE) begin
          full_d = 1'b1;
          if (ovf_en_q) begin
            stk_rst_d = 1'b1;
          end
        end
        if (op == ras_pkg::RAS_OP_IRQ) begin
          pc_d = irq_high_in ? ras_pkg::HI_VECTOR : ras_pkg::LO_VECTOR;
        end
      end
      ras_pkg::RAS_OP_POP: begin
        pc_d = tos;
        if (sp_q == ras_pkg::SP_EMPTY) begin
          unf_d = 1'b1;
        end else begin
          sp_d = sp_q - ras_pkg::SP_ONE;
        end
      end
      default: ;
    endcase
  end

  // ==========================================================
  // apb answer: one wait state, zero-filled bytes
  always_comb begin
    prdata_d = 32'h00000000;
    pready_d = acc;
    pslverr_d = 1'b0;
    if (acc && !pwrite) begin
      case (a)
        ras_pkg::ADDR_POINTER: prdata_d = {24'h000000, full_q, unf_q, 1'b0, sp_q};
        ras_pkg::ADDR_TOP_LOW: prdata_d = {24'h000000, tos[7:0]};
        ras_pkg::ADDR_TOP_HIGH: prdata_d = {24'h000000, tos[15:8]};
        ras_pkg::ADDR_TOP_UPPER: prdata_d = {27'h0000000, tos[20:16]};
        ras_pkg::ADDR_CONFIG: prdata_d = {31'h00000000, ovf_en_q};
        ras_pkg::ADDR_PC: prdata_d = {11'h000, pc_q};
        default: pslverr_d = 1'b1;
      endcase
    end else if (acc) begin
      case (a)
        ras_pkg::ADDR_POINTER, ras_pkg::ADDR_TOP_LOW, ras_pkg::ADDR_TOP_HIGH,
        ras_pkg::ADDR_TOP_UPPER, ras_pkg::ADDR_CONFIG: pslverr_d = 1'b0;
        default: pslverr_d = 1'b1;
      endcase
    end
  end

  // ==========================================================
  // registers; stack reset clears these just as reset_in and por_in do
  always_ff @(posedge clk_in) begin
    if (reset_in || por_in || stk_rst_q) begin // power-on clears the pointer too
      sp_q <= ras_pkg::SP_EMPTY;
      pc_q <= ras_pkg::RESET_VECTOR;
      prdata_q <= 32'h00000000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      stk_rst_q <= 1'b0;
      dad_q <= 21'h000000;
      drd_q <= 1'b0;
    end else begin
      sp_q <= sp_d;
      pc_q <= pc_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      stk_rst_q <= stk_rst_d;
      dad_q <= data_addr_in; // separate data path
      drd_q <= data_rd_in;
    end
  end

  // flags and configuration survive all resets but power-on
  always_ff @(posedge clk_in) begin
    if (por_in) begin
      full_q <= 1'b0;
      unf_q <= 1'b0;
      ovf_en_q <= ras_pkg::CFG_OVF_RESET_DEFAULT;
    end else begin
      full_q <= full_d;
      unf_q <= unf_d;
      ovf_en_q <= ovf_en_d;
    end
  end

  // stack array holds no reset; unwritten words are don't-care
  always_ff @(posedge clk_in) begin
    if (wr_en && wr_idx != ras_pkg::SP_EMPTY) begin
      stack_q[wr_idx] <= wr_val;
    end
  end

  // ==========================================================
  // instruction fetch on its own bus
  ras_prog_mem #(.SIZE_32K(SIZE_32K)) u_mem (
    .clk_in(clk_in),
    .addr_in(pc_q),
    .wr_in(1'b0),
    .wdata_in(16'h0000),
    .rdata_out(fetch_word)
  );

  logic [15:0] instr_q;
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      instr_q <= ras_pkg::NOP_WORD;
    end else begin
      instr_q <= fetch_word;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign pc_out = pc_q;
  assign instr_out = instr_q;
  assign data_addr_out = dad_q;
  assign data_rd_out = drd_q;
  assign stack_reset_out = stk_rst_q;

  // ==========================================================
  // checks
  sequence s_push_at(logic [4:0] v);
    push_in && !irq_ack_in && sp_q == v && !bus_wr;
  endsequence
  a_push_incr: assert property (@(posedge clk_in) disable iff (reset_in || por_in)
    s_push_at(5'h03) |=> sp_q == 5'h04) else $error("push did not increment");
  a_pop_decr: assert property (@(posedge clk_in) disable iff (reset_in || por_in)
    (pop_in && !push_in && !irq_ack_in && !bus_wr && sp_q == 5'h05 && !stk_rst_q)
    |=> sp_q == 5'h04) else $error("pop did not decrement");
  a_pop_empty: assert property (@(posedge clk_in) disable iff (reset_in || por_in)
    (pop_in && !push_in && !irq_ack_in && !bus_wr && sp_q == 5'h00 && !stk_rst_q)
    |=> unf_q && sp_q == 5'h00 && pc_q == 21'h000000) else $error("underflow");
  a_reset_sp: assert property (@(posedge clk_in) reset_in |=> sp_q == 5'h00)
    else $error("reset left pointer");
  a_irq_vector: assert property (@(posedge clk_in) disable iff (reset_in || por_in)
    (irq_ack_in && irq_high_in && sp_q < 5'h1D && !stk_rst_q) |=> pc_q == 21'h000008)
    else $error("bad high vector");
  a_full_set: assert property (@(posedge clk_in) disable iff (reset_in || por_in)
    (push_in && sp_q == 5'h1E && !stk_rst_q) |=> full_q) else $error("full not set");
  a_ovf_reset: assert property (@(posedge clk_in) disable iff (reset_in || por_in)
    (push_in && sp_q == 5'h1E && ovf_en_q && !stk_rst_q) |=> stk_rst_q ##1 sp_q == 5'h00)
    else $error("no overflow reset");
  a_hold_top: assert property (@(posedge clk_in) disable iff (reset_in || por_in)
    (push_in && sp_q == 5'h1F && !ovf_en_q && !bus_wr && !stk_rst_q) |=> sp_q == 5'h1F)
    else $error("pointer moved past limit");
  a_apb_ready: assert property (@(posedge clk_in) disable iff (reset_in)
    (psel && penable && !pready) |=> pready) else $error("apb answer late");
endmodule

// ### sim/ras_seq_model.sv
// file: instruction sequencer stand-in that issues stack events
`timescale 1ns/1ns
// ==========================================
// sequencer model
module ras_seq_model (
  input wire ras_pkg::ras_op_t op_in,
  input wire logic hi_in,
  input wire logic mask_in,
  input wire logic br_in,
  input wire logic [20:0] br_pc_in,
  output logic push_out,
  output logic pop_out,
  output logic irq_ack_out,
  output logic irq_high_out,
  output logic branch_out,
  output logic [20:0] branch_pc_out
);
  // one decoded event per cycle, held as long as the bench holds the op
  assign push_out = (op_in == ras_pkg::RAS_OP_PUSH);
  assign pop_out = (op_in == ras_pkg::RAS_OP_POP);
  // acknowledge held off while software edits the top word, so no stray push
  assign irq_ack_out = (op_in == ras_pkg::RAS_OP_IRQ) && !mask_in;
  assign irq_high_out = hi_in;
  assign branch_out = br_in;
  assign branch_pc_out = br_pc_in;
endmodule

// ### sim/return_address_stack_test.sv
// file: self-checking bench for the return address stack block
`timescale 1ns/1ns
module return_address_stack_test;
  logic clk_in, reset_in, por_in, hi, mask, br, data_rd_in, psel, penable, pwrite, e;
  logic pready, pslverr, push_in, pop_in, irq_ack_in, irq_high_in, branch_in;
  logic data_rd_out, stack_reset_out;
  ras_pkg::ras_op_t op;
  logic [20:0] br_pc, data_addr_in, pc_out, data_addr_out, branch_pc_in;
  logic [31:0] paddr, pwdata, prdata, r;
  logic [15:0] instr_out;
  int miscompares = 0;
  int compares = 0;
  // ==========================================
  // clock, partner and design
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  ras_seq_model seq (.op_in(op), .hi_in(hi), .mask_in(mask), .br_in(br), .br_pc_in(br_pc),
    .push_out(push_in), .pop_out(pop_in), .irq_ack_out(irq_ack_in),
    .irq_high_out(irq_high_in), .branch_out(branch_in), .branch_pc_out(branch_pc_in));
  ras_top #(.SIZE_32K(1'b1)) DUT (.clk_in(clk_in), .reset_in(reset_in), .por_in(por_in),
    .push_in(push_in), .pop_in(pop_in), .irq_ack_in(irq_ack_in), .irq_high_in(irq_high_in),
    .branch_pc_in(branch_pc_in), .branch_in(branch_in), .data_addr_in(data_addr_in),
    .data_rd_in(data_rd_in), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pc_out(pc_out),
    .instr_out(instr_out), .data_addr_out(data_addr_out), .data_rd_out(data_rd_out),
    .stack_reset_out(stack_reset_out));
  // ==========================================
  // tasks
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask
  // one apb transfer; request held until pready is sampled high
  task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_in);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= {20'h00000, a};
    pwrite <= w;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    // no cycle count assumed here; the watchdog ends a hung wait
    do begin
      @(posedge clk_in);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd(input logic [11:0] a, input logic [31:0] exp);
    apb(a, 1'b0, 32'h00000000);
    chk(r, exp);
  endtask
  // one stack event for exactly one cycle, then let its edge land
  task ev(input ras_pkg::ras_op_t o, input logic h);
    @(posedge clk_in);
    op <= o;
    hi <= h;
    @(posedge clk_in);
    op <= ras_pkg::RAS_OP_IDLE;
    #1;
  endtask
  task finish_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // watchdog: the sequence needs well under a thousand cycles
  initial begin
    #100000;
    miscompares++;
    finish_test();
  end
  // ==========================================
  // main sequence
  initial begin
    int i;
    {reset_in, por_in} = 2'b11;
    {hi, mask, br, data_rd_in, psel, penable, pwrite} = 7'h00;
    op = ras_pkg::RAS_OP_IDLE;
    br_pc = 21'h000000;
    data_addr_in = 21'h000000;
    paddr = 32'h00000000;
    pwdata = 32'h00000000;
    repeat (8) @(posedge clk_in);
    #1;
    chk({11'h000, pc_out}, {11'h000, ras_pkg::RESET_VECTOR});
    @(posedge clk_in);
    reset_in <= 1'b0;
    por_in <= 1'b0;
    rd(ras_pkg::ADDR_POINTER, 32'h00000000);
    apb(ras_pkg::ADDR_TOP_LOW, 1'b1, 32'h0000005A);
    rd(ras_pkg::ADDR_TOP_LOW, 32'h00000000);
    apb(12'h020, 1'b0, 32'h00000000);
    chk(e, 1'b1);
    // push, replace the top word with interrupts held off, then return to it
    ev(ras_pkg::RAS_OP_PUSH, 1'b0);
    rd(ras_pkg::ADDR_POINTER, 32'h00000001);
    @(posedge clk_in);
    mask <= 1'b1;
    apb(ras_pkg::ADDR_TOP_LOW, 1'b1, 32'h00000034);
    apb(ras_pkg::ADDR_TOP_HIGH, 1'b1, 32'h00000012);
    apb(ras_pkg::ADDR_TOP_UPPER, 1'b1, 32'h000000E5);
    rd(ras_pkg::ADDR_TOP_UPPER, 32'h00000005);
    rd(ras_pkg::ADDR_TOP_HIGH, 32'h00000012);
    rd(ras_pkg::ADDR_TOP_LOW, 32'h00000034);
    mask <= 1'b0;
    ev(ras_pkg::RAS_OP_POP, 1'b0);
    chk({11'h000, pc_out}, 32'h00051234);
    rd(ras_pkg::ADDR_POINTER, 32'h00000000);
    // pop on an empty stack
    ev(ras_pkg::RAS_OP_POP, 1'b0);
    chk({11'h000, pc_out}, 32'h00000000);
    rd(ras_pkg::ADDR_POINTER, 32'h00000040);
    apb(ras_pkg::ADDR_POINTER, 1'b1, 32'h00000000);
    rd(ras_pkg::ADDR_POINTER, 32'h00000000);
    // interrupts of both priorities
    ev(ras_pkg::RAS_OP_IRQ, 1'b1);
    chk({11'h000, pc_out}, {11'h000, ras_pkg::HI_VECTOR});
    ev(ras_pkg::RAS_OP_IRQ, 1'b0);
    chk({11'h000, pc_out}, {11'h000, ras_pkg::LO_VECTOR});
    rd(ras_pkg::ADDR_POINTER, 32'h00000002);
    apb(ras_pkg::ADDR_POINTER, 1'b1, 32'h00000004);
    rd(ras_pkg::ADDR_POINTER, 32'h00000004);
    // push to five so the word is written, then pop it back to four
    ev(ras_pkg::RAS_OP_PUSH, 1'b0);
    rd(ras_pkg::ADDR_POINTER, 32'h00000005);
    ev(ras_pkg::RAS_OP_POP, 1'b0);
    rd(ras_pkg::ADDR_POINTER, 32'h00000004);
    // overflow with the reset disabled: pointer holds at the limit
    apb(ras_pkg::ADDR_POINTER, 1'b1, 32'h00000000);
    apb(ras_pkg::ADDR_CONFIG, 1'b1, 32'h00000000);
    for (i = 0; i < 31; i++) ev(ras_pkg::RAS_OP_PUSH, 1'b0);
    rd(ras_pkg::ADDR_POINTER, 32'h0000009F);
    ev(ras_pkg::RAS_OP_PUSH, 1'b0);
    chk(stack_reset_out, 1'b0);
    rd(ras_pkg::ADDR_POINTER, 32'h0000009F);
    // power-on reset, then overflow with the reset enabled
    @(posedge clk_in);
    {reset_in, por_in} <= 2'b11;
    @(posedge clk_in);
    {reset_in, por_in} <= 2'b00;
    rd(ras_pkg::ADDR_POINTER, 32'h00000000);
    rd(ras_pkg::ADDR_CONFIG, 32'h00000001);
    apb(ras_pkg::ADDR_POINTER, 1'b1, 32'h0000001E);
    ev(ras_pkg::RAS_OP_PUSH, 1'b0);
    chk(stack_reset_out, 1'b1);
    repeat (2) @(posedge clk_in);
    rd(ras_pkg::ADDR_POINTER, 32'h00000080);
    // fetch beyond the implemented memory
    @(posedge clk_in);
    br <= 1'b1;
    br_pc <= 21'h010000;
    @(posedge clk_in);
    br <= 1'b0;
    repeat (3) @(posedge clk_in);
    #1;
    chk({16'h0000, instr_out}, {16'h0000, ras_pkg::NOP_WORD});
    // data bus runs beside the program bus
    @(posedge clk_in);
    data_addr_in <= 21'h00ABCD;
    data_rd_in <= 1'b1;
    @(posedge clk_in);
    #1;
    chk({11'h000, data_addr_out}, 32'h0000ABCD);
    chk(data_rd_out, 1'b1);
    finish_test();
  end
endmodule
